// >>> verilog/pin_override_pkg.sv
// constants for the port a / port b alternate-function override block
// assumes a single 100 MHz system clock
package pin_override_pkg;
  localparam int PORTA_PINS      = 8;
  localparam int PORTB_PINS      = 4;
  localparam int PIN_COUNT       = 12;
  localparam int PORTB_BASE      = 8;
  localparam int PA_COMP_POS     = 1;
  localparam int PA_COMP_NEG     = 2;
  localparam int PA_COUNT_PIN    = 4;
  localparam int PA_COMPARE_PIN  = 5;
  localparam int PA_TWO_WIRE_PIN = 7;
  localparam int PB_IRQ_PIN      = 10;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SPIKE_FILTER_NS = 50;
  localparam int SPIKE_CYCLES    = (SPIKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPIKE_CNT_W     = 4;
endpackage

// >>> verilog/port_ab_alt_function_override.sv
// per-pin alternate-function overrides and peripheral taps for port a and port b
// assumes pad inputs already synchronous to clk_in; analog paths modelled as levels
// Overview of operation
// - port a pin n is group a source n
// - port b pins are group b sources 8-11
// - port b pins feed converter channels 8-11
// - pin five output forced by compare b
// - port a input buffer force from mask/enable/disable
// - port a pins 0-4 output forces zero
// - pins 1,2 feed converter and comparator
// - two-wire enable turns on pin 7 slew/filter
// - spike filter sits between pad and two-wire
// - port b output forces held at zero
// - port b buffer force sel is three-way and
// - port b buffer force level is mask and enable
// - port b pin two feeds irq, source, spi
// - forced output value replaces data bit when driving
// - buffer force overrides normal/sleep state
// - direction force replaces direction register bit
`timescale 1ns/1ps
module port_ab_alt_function_override
  import pin_override_pkg::*;
#(
  parameter int FILTER_CYCLES = pin_override_pkg::SPIKE_CYCLES
)
(
  input  wire logic                              clk_in,
  input  wire logic                              nrst_in,
  input  wire logic [pin_override_pkg::PIN_COUNT-1:0] port_data_in,
  input  wire logic [pin_override_pkg::PIN_COUNT-1:0] port_dir_in,
  input  wire logic [pin_override_pkg::PIN_COUNT-1:0] port_pullup_in,
  input  wire logic [pin_override_pkg::PIN_COUNT-1:0] pin_change_mask_bit_in,
  input  wire logic                              pin_change_group_a_enable_in,
  input  wire logic                              pin_change_group_b_enable_in,
  input  wire logic [pin_override_pkg::PIN_COUNT-1:0] analog_pin_digital_off_in,
  input  wire logic                              timer_a_compare_b_out_in,
  input  wire logic                              timer_a_compare_b_route_on_in,
  input  wire logic                              inbuf_state_enable_in,
  input  wire logic [pin_override_pkg::PIN_COUNT-1:0] pad_sense_to_peripherals_in,
  input  wire logic [pin_override_pkg::PIN_COUNT-1:0] pad_analog_link_in,
  input  wire logic                              two_wire_serial_unit_enable_in,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] pullup_force_sel_out,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] pullup_force_level_out,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] direction_force_sel_out,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] direction_force_level_out,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] outvalue_force_sel_out,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] outvalue_force_level_out,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] invert_force_sel_out,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] inbuf_force_sel_out,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] inbuf_force_level_out,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] pad_drive_en_out,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] pad_level_out,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] pad_pullup_out,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] pad_inbuf_en_out,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] pin_change_src_out,
  output logic      [pin_override_pkg::PIN_COUNT-1:0] adc_channel_out,
  output logic                                   comparator_pos_out,
  output logic                                   comparator_neg_out,
  output logic                                   timer_a_count_pin_out,
  output logic                                   external_irq_zero_src_out,
  output logic                                   spi_master_data_out,
  output logic                                   two_wire_slew_limit_out,
  output logic                                   two_wire_filtered_out
);
  import pin_override_pkg::*;

  initial
  begin
    if (FILTER_CYCLES < 1 || FILTER_CYCLES >= (1 << SPIKE_CNT_W))
      $error("FILTER_CYCLES out of range");
  end

  // port a override terms
  genvar n;
  generate
    for (n = 0; n < PORTA_PINS; n++)
    begin : g_port_a
      logic pc_on;
      assign pc_on = pin_change_mask_bit_in[n] & pin_change_group_a_enable_in;
      assign pullup_force_sel_out[n]      = 1'b0;
      assign pullup_force_level_out[n]    = 1'b0;
      assign direction_force_sel_out[n]   = 1'b0;
      assign direction_force_level_out[n] = 1'b0;
      assign invert_force_sel_out[n]      = 1'b0;
      if (n == PA_COMPARE_PIN)
      begin : g_cmp
        assign outvalue_force_sel_out[n]   = timer_a_compare_b_route_on_in;
        assign outvalue_force_level_out[n] = timer_a_compare_b_out_in;
      end
      else
      begin : g_plain
        assign outvalue_force_sel_out[n]   = 1'b0;
        assign outvalue_force_level_out[n] = 1'b0;
      end
      assign inbuf_force_sel_out[n]   = pc_on | analog_pin_digital_off_in[n];
      assign inbuf_force_level_out[n] = pc_on;
      assign pin_change_src_out[n]    = pad_sense_to_peripherals_in[n];
      assign adc_channel_out[n]       = pad_analog_link_in[n];
    end

    // port b override terms
    for (n = PORTB_BASE; n < PIN_COUNT; n++)
    begin : g_port_b
      logic pc_on;
      assign pc_on = pin_change_mask_bit_in[n] & pin_change_group_b_enable_in;
      assign pullup_force_sel_out[n]      = 1'b0;
      assign pullup_force_level_out[n]    = 1'b0;
      assign direction_force_sel_out[n]   = 1'b0;
      assign direction_force_level_out[n] = 1'b0;
      assign outvalue_force_sel_out[n]    = 1'b0;
      assign outvalue_force_level_out[n]  = 1'b0;
      assign invert_force_sel_out[n]      = 1'b0;
      assign inbuf_force_sel_out[n]   = pc_on & analog_pin_digital_off_in[n];
      assign inbuf_force_level_out[n] = pc_on;
      assign pin_change_src_out[n]    = pad_sense_to_peripherals_in[n];
      assign adc_channel_out[n]       = pad_analog_link_in[n];
    end

    // pad resolution per pin
    for (n = 0; n < PIN_COUNT; n++)
    begin : g_resolve
      assign pad_drive_en_out[n] = direction_force_sel_out[n] ?
                                   direction_force_level_out[n] : port_dir_in[n];
      assign pad_level_out[n]    = outvalue_force_sel_out[n] ? outvalue_force_level_out[n] :
                                   (port_data_in[n] ^ invert_force_sel_out[n]);
      assign pad_pullup_out[n]   = pullup_force_sel_out[n] ?
                                   pullup_force_level_out[n] : port_pullup_in[n];
      assign pad_inbuf_en_out[n] = inbuf_force_sel_out[n] ?
                                   inbuf_force_level_out[n] : inbuf_state_enable_in;
    end
  endgenerate

  // peripheral taps, no register stage
  always_comb
  begin
    comparator_pos_out        = pad_analog_link_in[PA_COMP_POS];
    comparator_neg_out        = pad_analog_link_in[PA_COMP_NEG];
    timer_a_count_pin_out     = pad_sense_to_peripherals_in[PA_COUNT_PIN];
    external_irq_zero_src_out = pad_sense_to_peripherals_in[PB_IRQ_PIN];
    spi_master_data_out       = pad_sense_to_peripherals_in[PB_IRQ_PIN];
  end

  // two-wire spike filter on pin 7 analog path
  logic                   filt_r;
  logic                   filt_nxt;
  logic [SPIKE_CNT_W-1:0] cnt_r;
  logic [SPIKE_CNT_W-1:0] cnt_nxt;
  logic                   slew_r;
  logic                   slew_nxt;
  logic                   tw_in;

  assign tw_in = pad_analog_link_in[PA_TWO_WIRE_PIN];

  always_comb
  begin
    filt_nxt = filt_r;
    cnt_nxt  = '0;
    slew_nxt = two_wire_serial_unit_enable_in;
    if (!two_wire_serial_unit_enable_in)
      filt_nxt = tw_in;
    else if (tw_in != filt_r)
    begin
      if (cnt_r == SPIKE_CNT_W'(FILTER_CYCLES - 1))
        filt_nxt = tw_in;
      else
        cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      filt_r <= 1'b1;
      cnt_r  <= '0;
      slew_r <= 1'b0;
    end
    else
    begin
      filt_r <= filt_nxt;
      cnt_r  <= cnt_nxt;
      slew_r <= slew_nxt;
    end
  end

  assign two_wire_filtered_out   = filt_r;
  assign two_wire_slew_limit_out = slew_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_pa_inbuf_sel: assert property (inbuf_force_sel_out[7:0] == ((pin_change_mask_bit_in[7:0] &
    {8{pin_change_group_a_enable_in}}) | analog_pin_digital_off_in[7:0]))
    else $error("port a buffer force select wrong");
  a_pb_inbuf_sel: assert property (inbuf_force_sel_out[11:8] == (pin_change_mask_bit_in[11:8] &
    {4{pin_change_group_b_enable_in}} & analog_pin_digital_off_in[11:8]))
    else $error("port b buffer force select wrong");
  a_pb_inbuf_lvl: assert property (inbuf_force_level_out[11:8] == (pin_change_mask_bit_in[11:8] &
    {4{pin_change_group_b_enable_in}}))
    else $error("port b buffer force level wrong");
  a_pa5_drive_val: assert property (timer_a_compare_b_route_on_in |->
    pad_level_out[PA_COMPARE_PIN] == timer_a_compare_b_out_in)
    else $error("compare output not on pin five");
  a_pin_drive_dir: assert property (pad_drive_en_out == port_dir_in)
    else $error("drive enable not from direction bit");
  a_pad_level_data: assert property (!timer_a_compare_b_route_on_in |-> pad_level_out == port_data_in)
    else $error("pad level not from data bit");
  a_inbuf_state: assert property ((inbuf_force_sel_out == '0) |->
    pad_inbuf_en_out == {PIN_COUNT{inbuf_state_enable_in}})
    else $error("buffer enable not from state");
  a_pin_change_route: assert property (pin_change_src_out == pad_sense_to_peripherals_in)
    else $error("pin change sources misrouted");
  a_taps_route: assert property (timer_a_count_pin_out == pad_sense_to_peripherals_in[4] &&
    spi_master_data_out == pad_sense_to_peripherals_in[10] && external_irq_zero_src_out == spi_master_data_out)
    else $error("peripheral taps misrouted");
  a_slew_follow: assert property (two_wire_serial_unit_enable_in |=> two_wire_slew_limit_out)
    else $error("slew limit not set");
  a_filter_hold: assert property (two_wire_serial_unit_enable_in && $past(two_wire_serial_unit_enable_in) &&
    $changed(filt_r) |-> $past(cnt_r) == SPIKE_CNT_W'(FILTER_CYCLES - 1))
    else $error("filter changed before hold time");
  a_adc_route: assert property (adc_channel_out == pad_analog_link_in)
    else $error("converter channels misrouted");

  // fixed forces, routing and resolution
  a_pullup_fixed: assert property (pullup_force_sel_out == '0 && pullup_force_level_out == '0)
    else $error("pull-up force not zero");
  a_dir_fixed: assert property (direction_force_sel_out == '0 && direction_force_level_out == '0)
    else $error("direction force not zero");
  a_invert_fixed: assert property (invert_force_sel_out == '0)
    else $error("invert force not zero");
  a_pb_out_fixed: assert property (outvalue_force_sel_out[11:8] == '0 &&
    outvalue_force_level_out[11:8] == '0)
    else $error("port b value force not zero");
  a_pb_drive_dir: assert property (pad_drive_en_out[11:8] == port_dir_in[11:8])
    else $error("port b drive enable not from direction bit");
  a_pa5_force_sel: assert property (outvalue_force_sel_out[PA_COMPARE_PIN] == timer_a_compare_b_route_on_in)
    else $error("pin five force select wrong");
  a_pa5_force_lvl: assert property (outvalue_force_level_out[PA_COMPARE_PIN] == timer_a_compare_b_out_in)
    else $error("pin five force level wrong");
  a_pa_out_others: assert property ((outvalue_force_sel_out[7:0] & 8'hDF) == 8'h00)
    else $error("port a value force on wrong pin");
  a_pa_inbuf_lvl: assert property (inbuf_force_level_out[7:0] == (pin_change_mask_bit_in[7:0] &
    {8{pin_change_group_a_enable_in}}))
    else $error("port a buffer force level wrong");
  a_inbuf_forced: assert property (pad_inbuf_en_out == ((inbuf_force_sel_out & inbuf_force_level_out) |
    (~inbuf_force_sel_out & {PIN_COUNT{inbuf_state_enable_in}})))
    else $error("buffer enable resolution wrong");
  a_pad_pullup: assert property (pad_pullup_out == port_pullup_in)
    else $error("pad pull-up not from register bit");
  a_pb_level_data: assert property (pad_level_out[11:8] == port_data_in[11:8])
    else $error("port b pad level not from data bit");
  a_pb_pin_change: assert property (pin_change_src_out[11:8] == pad_sense_to_peripherals_in[11:8])
    else $error("port b pin change sources misrouted");
  a_comp_route: assert property (comparator_pos_out == pad_analog_link_in[PA_COMP_POS] &&
    comparator_neg_out == pad_analog_link_in[PA_COMP_NEG])
    else $error("comparator inputs misrouted");
  a_irq_tap: assert property (external_irq_zero_src_out == pad_sense_to_peripherals_in[PB_IRQ_PIN])
    else $error("external irq tap misrouted");
  a_timer_tap: assert property (timer_a_count_pin_out == pad_sense_to_peripherals_in[PA_COUNT_PIN])
    else $error("timer count tap misrouted");

  // two-wire filter behaviour
  a_slew_clear: assert property (!two_wire_serial_unit_enable_in |=> !two_wire_slew_limit_out)
    else $error("slew limit not cleared");
  a_cnt_clear: assert property (!two_wire_serial_unit_enable_in |=> cnt_r == '0)
    else $error("filter count not cleared");
  a_filter_copy: assert property (!two_wire_serial_unit_enable_in |=> two_wire_filtered_out == $past(tw_in))
    else $error("filter not copying while off");
  a_filter_idle: assert property (two_wire_serial_unit_enable_in && tw_in == filt_r |=>
    cnt_r == '0 && $stable(filt_r))
    else $error("filter moved on steady input");
  a_cnt_bound: assert property (cnt_r < SPIKE_CNT_W'(FILTER_CYCLES))
    else $error("filter count past limit");

  c_compare_drive: cover property (timer_a_compare_b_route_on_in && port_dir_in[PA_COMPARE_PIN]);
  c_filter_pass: cover property (two_wire_serial_unit_enable_in && $changed(filt_r));
  c_filter_spike: cover property (two_wire_serial_unit_enable_in && cnt_r != '0 ##1 cnt_r == '0 && !$changed(filt_r));
  c_pb_force: cover property (inbuf_force_sel_out[11:8] != '0);
  c_pa_inbuf_off: cover property (inbuf_force_sel_out[7:0] != '0 && inbuf_force_level_out[7:0] == '0);
endmodule

// >>> tb/tb_port_ab_alt_function_override.sv
// self-checking bench for the port a / port b override block
// assumes the package is compiled first; filter shortened to two cycles
`timescale 1ns/1ps
module tb_port_ab_alt_function_override;
  import pin_override_pkg::*;
  localparam int FC = 2;
  logic                 clk_in, nrst_in, ga, gb, cmp, route, st, tw;
  logic [PIN_COUNT-1:0] dat, dir, pu, msk, off, sns, ana;
  logic [PIN_COUNT-1:0] pus, pul, dis, dil, ovs, ovl, ivs, ibs, ibl, pde, plv, ppu, pie, pcs, adc;
  logic                 cpos, cneg, tmr, irq, spi, slew, filt;
  logic [31:0]          r1, r2, r3;
  int                   n_fail, total_checks, seed;

  port_ab_alt_function_override #(.FILTER_CYCLES(FC)) dut_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .port_data_in(dat), .port_dir_in(dir), .port_pullup_in(pu),
    .pin_change_mask_bit_in(msk), .pin_change_group_a_enable_in(ga), .pin_change_group_b_enable_in(gb),
    .analog_pin_digital_off_in(off), .timer_a_compare_b_out_in(cmp), .timer_a_compare_b_route_on_in(route),
    .inbuf_state_enable_in(st), .pad_sense_to_peripherals_in(sns), .pad_analog_link_in(ana),
    .two_wire_serial_unit_enable_in(tw), .pullup_force_sel_out(pus), .pullup_force_level_out(pul),
    .direction_force_sel_out(dis), .direction_force_level_out(dil), .outvalue_force_sel_out(ovs),
    .outvalue_force_level_out(ovl), .invert_force_sel_out(ivs), .inbuf_force_sel_out(ibs),
    .inbuf_force_level_out(ibl), .pad_drive_en_out(pde), .pad_level_out(plv), .pad_pullup_out(ppu),
    .pad_inbuf_en_out(pie), .pin_change_src_out(pcs), .adc_channel_out(adc), .comparator_pos_out(cpos),
    .comparator_neg_out(cneg), .timer_a_count_pin_out(tmr), .external_irq_zero_src_out(irq),
    .spi_master_data_out(spi), .two_wire_slew_limit_out(slew), .two_wire_filtered_out(filt));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_vec(input logic [PIN_COUNT-1:0] got, input logic [PIN_COUNT-1:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic step();
    @(posedge clk_in);
    #1;
  endtask

  // expected overrides and taps worked out from the current inputs
  task automatic check_comb();
    logic [PIN_COUNT-1:0] es, el, eo, ev;
    es = {msk[11:8] & {4{gb}} & off[11:8], (msk[7:0] & {8{ga}}) | off[7:0]};
    el = msk & {{4{gb}}, {8{ga}}};
    eo = '0;
    eo[PA_COMPARE_PIN] = route;
    ev = '0;
    ev[PA_COMPARE_PIN] = cmp;
    chk_vec(pus | pul | dis | dil | ivs, 12'h000, "fixed forces");
    chk_vec(ovs, eo, "outvalue sel");
    chk_vec(ovl, ev, "outvalue level");
    chk_vec(ibs, es, "inbuf sel");
    chk_vec(ibl, el, "inbuf level");
    chk_vec(pde, dir, "drive enable");
    chk_vec(plv, (eo & ev) | (~eo & dat), "pad level");
    chk_vec(ppu, pu, "pad pullup");
    chk_vec(pie, (es & el) | (~es & {PIN_COUNT{st}}), "inbuf enable");
    chk_vec(pcs, sns, "pin change sources");
    chk_vec(adc, ana, "converter channels");
    chk_bit(cpos, ana[PA_COMP_POS], "comparator pos");
    chk_bit(cneg, ana[PA_COMP_NEG], "comparator neg");
    chk_bit(tmr, sns[PA_COUNT_PIN], "timer count");
    chk_bit(irq, sns[PB_IRQ_PIN], "external irq");
    chk_bit(spi, sns[PB_IRQ_PIN], "spi input");
  endtask

  initial
  begin
    repeat (2000) @(posedge clk_in);
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    seed = 10;
    n_fail = 0;
    total_checks = 0;
    nrst_in = 1'b0;
    {dat, dir, pu, msk, off, sns, ana, ga, gb, cmp, route, st, tw} = '0;
    repeat (20) step();
    chk_bit(slew, 1'b0, "slew after reset");
    chk_bit(filt, 1'b1, "filter after reset");
    nrst_in = 1'b1;
    // all-zero and all-one corners, then random traffic
    for (int k = 0; k < 302; k++)
    begin
      step();
      r1 = $random(seed);
      r2 = $random(seed);
      r3 = $random(seed);
      {dat, dir, ga, gb, cmp, route, st, tw} = r1[29:0];
      {pu, msk, off[3:0]} = r2[27:0];
      {off[11:4], sns, ana} = r3[31:0];
      if (k < 2)
        {dat, dir, pu, msk, off, sns, ana, ga, gb, cmp, route, st, tw} = {90{k[0]}};
      #1;
      check_comb();
    end
    tw = 1'b0;
    ana[PA_TWO_WIRE_PIN] = 1'b0;
    step();
    step();
    chk_bit(filt, 1'b0, "filter copy mode");
    tw = 1'b1;
    ana[PA_TWO_WIRE_PIN] = 1'b1;
    step();
    chk_bit(slew, 1'b1, "slew on");
    chk_bit(filt, 1'b0, "filter holds");
    step();
    chk_bit(filt, 1'b1, "filter settles");
    ana[PA_TWO_WIRE_PIN] = 1'b0;
    step();
    ana[PA_TWO_WIRE_PIN] = 1'b1;
    step();
    step();
    chk_bit(filt, 1'b1, "spike rejected");
    tw = 1'b0;
    step();
    chk_bit(slew, 1'b0, "slew off");
    tally_and_finish();
  end
endmodule
